/* File: pkg/adc_init_defs.svh */
// Offsets, field positions, reset values and timing counts for the converter init link
`ifndef ADC_INIT_DEFS_SVH
`define ADC_INIT_DEFS_SVH

// Converter register map (8-bit addresses on the serial link)
`define CONV_SWRST_ADDR       8'h00
`define CONV_SWRST_BIT        0
`define CONV_BYPASS_ADDR      8'h24
`define CONV_BYPASS_BIT       2
`define CONV_CODE_A_ADDR      8'h8F
`define CONV_CODE_B_ADDR      8'h92
`define CONV_CODE_BIT         1
`define CONV_CODE_MASK        8'h02
`define CONV_REG_RESET        8'h00

// Host APB register map (byte addresses)
`define HOST_CTRL_ADDR        12'h000
`define HOST_CMD_ADDR         12'h004
`define HOST_STATUS_ADDR      12'h008
`define HOST_RDATA_ADDR       12'h00C

// Host control fields
`define CTRL_INIT_GO_BIT      0
`define CTRL_REFERENCE_BUFFER_CONFIG_PIN_LVL_BIT   1
`define CTRL_HWRST_GO_BIT     2
`define CTRL_SWRST_GO_BIT     3

// Host command fields
`define CMD_WDATA_LSB         0
`define CMD_ADDR_LSB          8
`define CMD_WRITE_BIT         16
`define CMD_GO_BIT            17

// Host status fields
`define STAT_STATE_LSB        0
`define STAT_READY_BIT        3
`define STAT_BUSY_BIT         4
`define STAT_DONE_BIT         5

// Timing
`define CLK_PERIOD_NS         40
`define POWER_ON_MS           2
`define POWER_ON_CYC          ((`POWER_ON_MS * 1000000) / `CLK_PERIOD_NS)
`define REFERENCE_BUFFER_CONFIG_PIN_SETUP_NS       100
`define REFERENCE_BUFFER_CONFIG_PIN_SETUP_CYC      ((`REFERENCE_BUFFER_CONFIG_PIN_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_US        1
`define RESET_PULSE_CYC      ((`RESET_PULSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_CYCLES            200000
`define CNT_W                 18

`endif

/* File: pkg/adc_init_if.sv */
// Pin-level link between the host controller and the converter
`timescale 1ns/1ps
interface adc_init_if;
  logic                  reset_pin;
  logic                  reference_buffer_config_pin;
  logic                  sampling_clk_on;
  logic                  serial_port_select_n;
  logic                  reg_wr;
  adc_init_pkg::byte_t   reg_addr;
  adc_init_pkg::byte_t   reg_wdata;
  adc_init_pkg::byte_t   reg_rdata;

  modport host (
    output reset_pin,
    output reference_buffer_config_pin,
    output sampling_clk_on,
    output serial_port_select_n,
    output reg_wr,
    output reg_addr,
    output reg_wdata,
    input  reg_rdata
  );

  modport device (
    input  reset_pin,
    input  reference_buffer_config_pin,
    input  sampling_clk_on,
    input  serial_port_select_n,
    input  reg_wr,
    input  reg_addr,
    input  reg_wdata,
    output reg_rdata
  );
endinterface

/* File: pkg/adc_init_pkg.sv */
// Types shared by the host sequencer and the converter model
package adc_init_pkg;

  // Host sequencer states, Gray coded along the power-up path
  typedef enum logic [2:0] {
    seq_idle    = 3'b000,
    seq_pwr     = 3'b001,
    seq_reference_buffer_config_pin  = 3'b011,
    seq_rst     = 3'b010,
    seq_cal     = 3'b110,
    seq_ready   = 3'b111,
    seq_access  = 3'b101,
    seq_capture = 3'b100
  } seq_state_t;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] sample_t;

endpackage

/* File: src/adc_conv.sv */
// Converter end: reset pin, software reset, calibration wait and coding registers
`timescale 1ns/1ps
`include "adc_init_defs.svh"
module adc_conv #(
  parameter int unsigned CAL_CYCLES = `CAL_CYCLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  adc_init_if.device                 link,
  input  wire adc_init_pkg::sample_t sample_a_in,
  input  wire adc_init_pkg::sample_t sample_b_in,
  output adc_init_pkg::sample_t      sample_a_out,
  output adc_init_pkg::sample_t      sample_b_out,
  output logic                       calib_busy,
  output logic                       reference_buffer_config_pin_mode
);
  adc_init_pkg::byte_t   bypass_ff;
  adc_init_pkg::byte_t   code_a_ff;
  adc_init_pkg::byte_t   code_b_ff;
  adc_init_pkg::byte_t   rdata_ff;
  logic                  swrst_ff;
  logic                  pin_prev_ff;
  logic                  reference_buffer_config_pin_ff;
  logic [`CNT_W-1:0]     cal_cnt_ff;
  logic                  acc;
  logic                  wr;
  logic                  cal_start;

  // Accesses are dropped while held in reset or calibrating
  assign acc       = ~link.serial_port_select_n & ~link.reset_pin & ~calib_busy;
  assign wr        = acc & link.reg_wr;
  assign cal_start = (pin_prev_ff & ~link.reset_pin) | swrst_ff;
  assign calib_busy = (cal_cnt_ff != '0);

  //////////////////////////////////////////////////////////////////////////////
  // software reset strobe
  // The bit reads 1 for one cycle, then clears itself
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      swrst_ff <= 1'b0;
    end else if (wr && link.reg_addr == `CONV_SWRST_ADDR) begin
      swrst_ff <= link.reg_wdata[`CONV_SWRST_BIT];
    end else begin
      swrst_ff <= 1'b0;
    end
  end

  // Reset pin edge detect and reference buffer level capture at the rising edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_prev_ff <= 1'b0;
      reference_buffer_config_pin_ff   <= 1'b0;
    end else begin
      pin_prev_ff <= link.reset_pin;
      if (link.reset_pin && !pin_prev_ff) begin
        reference_buffer_config_pin_ff <= link.reference_buffer_config_pin;
      end
    end
  end

  // calibration count on the sampling clock after reset release
  // Counts only while the sampling clock is applied
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_cnt_ff <= '0;
    end else if (link.reset_pin) begin
      cal_cnt_ff <= '0;
    end else if (cal_start) begin
      cal_cnt_ff <= `CNT_W'(CAL_CYCLES);
    end else if (calib_busy && link.sampling_clk_on) begin
      cal_cnt_ff <= cal_cnt_ff - `CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // defaults (CONV_REG_RESET) load while the reset pin is high; a software reset restores them too
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bypass_ff <= `CONV_REG_RESET;
      code_a_ff <= `CONV_REG_RESET;
      code_b_ff <= `CONV_REG_RESET;
    end else if (link.reset_pin || swrst_ff) begin
      bypass_ff <= `CONV_REG_RESET;
      code_a_ff <= `CONV_REG_RESET;
      code_b_ff <= `CONV_REG_RESET;
    end else if (wr) begin
      unique case (link.reg_addr)
        `CONV_BYPASS_ADDR: bypass_ff <= link.reg_wdata;
        `CONV_CODE_A_ADDR: code_a_ff <= link.reg_wdata;  // Unused bits kept as written
        `CONV_CODE_B_ADDR: code_b_ff <= link.reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data lands one cycle after the select cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (acc) begin
      unique case (link.reg_addr)
        `CONV_SWRST_ADDR:  rdata_ff <= {7'h00, swrst_ff};
        `CONV_BYPASS_ADDR: rdata_ff <= bypass_ff;
        `CONV_CODE_A_ADDR: rdata_ff <= code_a_ff;
        `CONV_CODE_B_ADDR: rdata_ff <= code_b_ff;
        default:           rdata_ff <= 8'h00;
      endcase
    end
  end

  assign link.reg_rdata = rdata_ff;
  assign reference_buffer_config_pin_mode    = reference_buffer_config_pin_ff;

  //////////////////////////////////////////////////////////////////////////////
  // channel A coding; gated by the bypass bit
  code_format u_fmt_a (
    .core_clk   (core_clk),
    .rst        (rst),
    .bypass_en  (bypass_ff[`CONV_BYPASS_BIT]),
    .offset_bin (code_a_ff[`CONV_CODE_BIT]),
    .sample_in  (sample_a_in),
    .sample_out (sample_a_out)
  );

  // channel B coding; gated by the bypass bit
  code_format u_fmt_b (
    .core_clk   (core_clk),
    .rst        (rst),
    .bypass_en  (bypass_ff[`CONV_BYPASS_BIT]),
    .offset_bin (code_b_ff[`CONV_CODE_BIT]),
    .sample_in  (sample_b_in),
    .sample_out (sample_b_out)
  );
endmodule

/* File: src/adc_host.sv */
// Host controller end: power-up sequencing and register access for the converter
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_init_defs.svh"
module adc_host #(
  parameter int unsigned POWER_ON_CYC = `POWER_ON_CYC,
  parameter int unsigned CAL_CYCLES   = `CAL_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  adc_init_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);
  adc_init_pkg::seq_state_t state_ff;
  adc_init_pkg::seq_state_t nxt_state;
  logic [`CNT_W-1:0]        cnt_ff;
  logic                     reference_buffer_config_pin_lvl_ff;
  logic                     clk_on_ff;
  logic                     done_ff;
  logic                     cmd_wr_ff;
  adc_init_pkg::byte_t      cmd_addr_ff;
  adc_init_pkg::byte_t      cmd_wdata_ff;
  adc_init_pkg::byte_t      rdata_ff;
  logic [31:0]              prdata_ff;
  logic                     pslverr_ff;
  logic                     apb_wr;
  logic                     apb_setup;
  logic                     go_init;
  logic                     go_hwrst;
  logic                     go_swrst;
  logic                     go_cmd;
  logic                     cnt_zero;
  logic                     mapped;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, so a write lands in its access cycle
  assign pready    = 1'b1;
  assign apb_wr    = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;
  assign go_init   = apb_wr && paddr == `HOST_CTRL_ADDR && pwdata[`CTRL_INIT_GO_BIT];
  assign go_hwrst  = apb_wr && paddr == `HOST_CTRL_ADDR && pwdata[`CTRL_HWRST_GO_BIT];
  assign go_swrst  = apb_wr && paddr == `HOST_CTRL_ADDR && pwdata[`CTRL_SWRST_GO_BIT];
  assign go_cmd    = apb_wr && paddr == `HOST_CMD_ADDR && pwdata[`CMD_GO_BIT];
  assign cnt_zero  = (cnt_ff == '0);
  assign mapped    = paddr == `HOST_CTRL_ADDR || paddr == `HOST_CMD_ADDR ||
                     paddr == `HOST_STATUS_ADDR || paddr == `HOST_RDATA_ADDR;

  // Reference pin level is held in a control bit; it only reaches the pin
  // once the power-on wait is over
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reference_buffer_config_pin_lvl_ff <= 1'b0;
    end else if (apb_wr && paddr == `HOST_CTRL_ADDR) begin
      reference_buffer_config_pin_lvl_ff <= pwdata[`CTRL_REFERENCE_BUFFER_CONFIG_PIN_LVL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer transitions; orders arriving in the wrong state are ignored
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      adc_init_pkg::seq_idle:    if (go_init) nxt_state = adc_init_pkg::seq_pwr;
      adc_init_pkg::seq_pwr:     if (cnt_zero) nxt_state = adc_init_pkg::seq_reference_buffer_config_pin;
      adc_init_pkg::seq_reference_buffer_config_pin:  if (cnt_zero) nxt_state = adc_init_pkg::seq_rst;
      adc_init_pkg::seq_rst:     if (cnt_zero) nxt_state = adc_init_pkg::seq_cal;
      adc_init_pkg::seq_cal:     if (cnt_zero) nxt_state = adc_init_pkg::seq_ready;
      adc_init_pkg::seq_ready: begin
        if (go_hwrst) begin
          nxt_state = adc_init_pkg::seq_reference_buffer_config_pin;
        end else if (go_swrst || go_cmd) begin
          nxt_state = adc_init_pkg::seq_access;
        end
      end
      adc_init_pkg::seq_access:  nxt_state = adc_init_pkg::seq_capture;
      adc_init_pkg::seq_capture: begin
        // A software reset write is followed by the calibration wait
        if (cmd_wr_ff && cmd_addr_ff == `CONV_SWRST_ADDR &&
            cmd_wdata_ff[`CONV_SWRST_BIT]) begin
          nxt_state = adc_init_pkg::seq_cal;
        end else begin
          nxt_state = adc_init_pkg::seq_ready;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= adc_init_pkg::seq_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // One shared down-counter, loaded on entry to each timed state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      unique case (nxt_state)
        // power-on wait before the reference pin
        adc_init_pkg::seq_pwr:    cnt_ff <= `CNT_W'(POWER_ON_CYC - 1);
        // reference pin settled before the reset edge
        adc_init_pkg::seq_reference_buffer_config_pin: cnt_ff <= `CNT_W'(`REFERENCE_BUFFER_CONFIG_PIN_SETUP_CYC - 1);
        adc_init_pkg::seq_rst:    cnt_ff <= `CNT_W'(`RESET_PULSE_CYC - 1);
        // calibration wait; also after a software reset
        adc_init_pkg::seq_cal:    cnt_ff <= `CNT_W'(CAL_CYCLES - 1);
        default:                  cnt_ff <= '0;
      endcase
    end else if (!cnt_zero) begin
      cnt_ff <= cnt_ff - `CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sampling clock is applied together with the reference level and stays on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_on_ff <= 1'b0;
    end else if (nxt_state == adc_init_pkg::seq_reference_buffer_config_pin) begin
      // Raised on the same edge as the reference pin, so both settle together
      clk_on_ff <= 1'b1;
    end
  end

  // Command latch; a software reset order becomes a write of the reset bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_wr_ff    <= 1'b0;
      cmd_addr_ff  <= 8'h00;
      cmd_wdata_ff <= 8'h00;
    end else if (state_ff == adc_init_pkg::seq_ready) begin
      if (go_swrst) begin
        cmd_wr_ff    <= 1'b1;
        cmd_addr_ff  <= `CONV_SWRST_ADDR;
        cmd_wdata_ff <= 8'h01;
      end else if (go_cmd) begin
        cmd_wr_ff   <= pwdata[`CMD_WRITE_BIT];
        cmd_addr_ff <= pwdata[`CMD_ADDR_LSB +: 8];
        // unused bits of the code registers are forced to zero
        if (pwdata[`CMD_ADDR_LSB +: 8] == `CONV_CODE_A_ADDR ||
            pwdata[`CMD_ADDR_LSB +: 8] == `CONV_CODE_B_ADDR) begin
          cmd_wdata_ff <= pwdata[`CMD_WDATA_LSB +: 8] & `CONV_CODE_MASK;
        end else begin
          cmd_wdata_ff <= pwdata[`CMD_WDATA_LSB +: 8];
        end
      end
    end
  end

  // Read capture and done flag; a finished access wins over a clearing go
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      done_ff  <= 1'b0;
    end else if (state_ff == adc_init_pkg::seq_capture) begin
      rdata_ff <= link.reg_rdata;
      done_ff  <= 1'b1;
    end else if (go_cmd || go_swrst) begin
      done_ff  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins toward the converter, all from flip-flops or state
  // reset pin high only in the pulse state; low otherwise
  assign link.reset_pin = (state_ff == adc_init_pkg::seq_rst);
  assign link.reference_buffer_config_pin = reference_buffer_config_pin_lvl_ff &
                                            (state_ff != adc_init_pkg::seq_idle) &
                                            (state_ff != adc_init_pkg::seq_pwr);
  assign link.sampling_clk_on = clk_on_ff;
  // select only asserted in the access state, after the wait
  assign link.serial_port_select_n = (state_ff != adc_init_pkg::seq_access);
  assign link.reg_wr    = cmd_wr_ff;
  assign link.reg_addr  = cmd_addr_ff;
  assign link.reg_wdata = cmd_wdata_ff;

  // APB read data prepared in the setup cycle, shown in the access cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      pslverr_ff <= ~mapped;
      unique case (paddr)
        `HOST_CTRL_ADDR:   prdata_ff <= {30'h0000_0000, reference_buffer_config_pin_lvl_ff, 1'b0};
        `HOST_CMD_ADDR:    prdata_ff <= {15'h0000, cmd_wr_ff, cmd_addr_ff, cmd_wdata_ff};
        `HOST_STATUS_ADDR: prdata_ff <= {26'h000_0000, done_ff,
                                         state_ff != adc_init_pkg::seq_ready &&
                                         state_ff != adc_init_pkg::seq_idle,
                                         state_ff == adc_init_pkg::seq_ready,
                                         state_ff};
        `HOST_RDATA_ADDR:  prdata_ff <= {24'h00_0000, rdata_ff};
        default:           prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;
endmodule

/* File: src/code_format.sv */
// One channel of output number coding: two's complement or offset binary
`timescale 1ns/1ps
`include "adc_init_defs.svh"
module code_format (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                bypass_en,
  input  wire logic                offset_bin,
  input  wire adc_init_pkg::sample_t sample_in,
  output adc_init_pkg::sample_t    sample_out
);
  adc_init_pkg::sample_t sample_ff;

  // Offset binary is two's complement with the sign bit flipped;
  // the choice only counts while the bypass path is on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sample_ff <= 16'h0000;
    end else begin
      sample_ff <= {sample_in[15] ^ (bypass_en & offset_bin), sample_in[14:0]};
    end
  end

  assign sample_out = sample_ff;
endmodule

/* File: verification/adc_init_assertions.sv */
// Link-level checks between host sequencer and converter
`timescale 1ns/1ps
`include "adc_init_defs.svh"
module adc_init_assertions #(
  parameter int unsigned CAL_CYCLES = 200000
) (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                reset_pin,
  input wire logic                reference_buffer_config_pin,
  input wire logic                sampling_clk_on,
  input wire logic                serial_port_select_n,
  input wire logic                reg_wr,
  input wire adc_init_pkg::byte_t reg_addr,
  input wire adc_init_pkg::byte_t reg_wdata,
  input wire adc_init_pkg::byte_t reg_rdata
);
  int unsigned hi_len_ff;
  int unsigned stb_len_ff;
  int unsigned since_rst_ff;
  logic        sel;
  logic        swrst;
  // Decoded access and software reset strobe
  assign sel   = !serial_port_select_n;
  assign swrst = sel && reg_wr && reg_addr == `CONV_SWRST_ADDR && reg_wdata[`CONV_SWRST_BIT];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Length of the current high pulse on the reset pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_len_ff <= 0;
    end else if (reset_pin) begin
      hi_len_ff <= hi_len_ff + 1;
    end else begin
      hi_len_ff <= 0;
    end
  end
  // Cycles the reference pin and clock enable stayed put; lags one edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stb_len_ff <= 0;
    end else if ($changed(reference_buffer_config_pin) || $changed(sampling_clk_on)) begin
      stb_len_ff <= 0;
    end else if (stb_len_ff < 255) begin
      stb_len_ff <= stb_len_ff + 1;
    end
  end
  // Cycles since any reset; saturates so a long run never wraps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_rst_ff <= 0;
    end else if (reset_pin || swrst) begin
      since_rst_ff <= 0;
    end else if (since_rst_ff < CAL_CYCLES) begin
      since_rst_ff <= since_rst_ff + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  reset_width_a: assert property (
    $fell(reset_pin) |-> hi_len_ff >= `RESET_PULSE_CYC) else $error("reset pulse too short");
  // Three cycles of 40 ns cover 100 ns; the counter trails by one
  reference_buffer_config_pin_setup_a: assert property (
    $rose(reset_pin) |-> sampling_clk_on && stb_len_ff >= 2)
    else $error("reference pin or clock not settled");
  clock_first_a: assert property (
    sel |-> sampling_clk_on) else $error("access without sampling clock");
  cal_wait_a: assert property (
    sel |-> since_rst_ff >= CAL_CYCLES) else $error("access inside calibration wait");
  quiet_in_reset_a: assert property (
    reset_pin |-> !sel) else $error("access while reset pin high");
  swrst_pin_low_a: assert property (
    swrst |-> !reset_pin ##1 !reset_pin) else $error("reset pin high at soft reset");
  code_mask_a: assert property (
    sel && reg_wr && (reg_addr == `CONV_CODE_A_ADDR || reg_addr == `CONV_CODE_B_ADDR)
    |-> (reg_wdata & ~`CONV_CODE_MASK) == 8'h00)
    else $error("reserved code bits written nonzero");
  swrst_clear_a: assert property (
    sel && !reg_wr && reg_addr == `CONV_SWRST_ADDR && since_rst_ff >= CAL_CYCLES
    |=> reg_rdata == 8'h00)
    else $error("soft reset bit still set");
  // Main scenarios reached
  cover property (swrst);
  cover property ($fell(reset_pin));
  cover property (sel && reg_wr && reg_addr == `CONV_CODE_A_ADDR);
endmodule

/* File: verification/adc_reset_init_and_output_format_test.sv */
// Bench joining host and converter, driving APB and sample inputs
`timescale 1ns/1ps
`include "adc_init_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module adc_reset_init_and_output_format_test;
  localparam int PWR   = 20;
  localparam int CAL   = 30;
  localparam int LIMIT = 20000;
  logic                  core_clk;
  logic                  rst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic                  pready;
  logic                  pslverr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  adc_init_pkg::sample_t sa_in;
  adc_init_pkg::sample_t sb_in;
  adc_init_pkg::sample_t sa_out;
  adc_init_pkg::sample_t sb_out;
  logic                  calib_busy;
  logic                  reference_buffer_config_pin_mode;
  logic                  cal_seen;
  logic                  lvl;
  logic                  er;
  logic [31:0]           seed;
  logic [31:0]           d;
  logic [31:0]           ev;
  int                    error_cnt;
  int                    checks;
  int                    cyc;
  int                    t0;
  adc_init_if link_if();
  ////////////////////////////////////////////////////////////////
  adc_host #(.POWER_ON_CYC(PWR), .CAL_CYCLES(CAL)) adc_host_inst (
    .core_clk(core_clk), .rst(rst), .link(link_if.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  adc_conv #(.CAL_CYCLES(CAL)) adc_conv_inst (
    .core_clk(core_clk), .rst(rst), .link(link_if.device),
    .sample_a_in(sa_in), .sample_b_in(sb_in), .sample_a_out(sa_out),
    .sample_b_out(sb_out), .calib_busy(calib_busy), .reference_buffer_config_pin_mode(reference_buffer_config_pin_mode));
  adc_init_assertions #(.CAL_CYCLES(CAL)) adc_init_assertions_inst (
    .core_clk(core_clk), .rst(rst), .reset_pin(link_if.reset_pin),
    .reference_buffer_config_pin(link_if.reference_buffer_config_pin),
    .sampling_clk_on(link_if.sampling_clk_on),
    .serial_port_select_n(link_if.serial_port_select_n), .reg_wr(link_if.reg_wr),
    .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
    .reg_rdata(link_if.reg_rdata));
  ////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Cycle count, calibration watch and hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (calib_busy === 1'b1) cal_seen = 1'b1;
    if (cyc == LIMIT) begin
      error_cnt++;
      close_out();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Offset binary is two's complement with the sign bit flipped
  function adc_init_pkg::sample_t exp_fmt(adc_init_pkg::sample_t s, logic on);
    return s ^ {on, 15'h0000};
  endfunction
  task close_out();
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; read data and error land in d and er
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Poll a status bit; gives up after 500 polls and fails the check
  task wait_bit(input int b);
    d = 32'h0;
    repeat (500) if (d[b] !== 1'b1) apb(1'b0, `HOST_STATUS_ADDR, 32'h0);
    `CHK("status bit", 1'b1, d[b])
  endtask
  // Converter register access through the command register
  task conv(input logic w, input logic [7:0] a, input logic [7:0] v);
    wait_bit(`STAT_READY_BIT);
    apb(1'b1, `HOST_CMD_ADDR, {14'h0, 1'b1, w, a, v});
    wait_bit(`STAT_DONE_BIT);
    if (!w) apb(1'b0, `HOST_RDATA_ADDR, 32'h0);
  endtask
  task sample_chk(input logic [31:0] s, input logic byp, input logic ca, input logic cb);
    sa_in <= s[15:0];
    sb_in <= s[31:16];
    @(posedge core_clk);
    @(posedge core_clk);
    `CHK("chan a out", exp_fmt(s[15:0], byp & ca), sa_out)
    `CHK("chan b out", exp_fmt(s[31:16], byp & cb), sb_out)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hF536;
    {psel, penable, pwrite, paddr, pwdata, sa_in, sb_in} = '0;
    {cal_seen, error_cnt, checks, cyc} = '0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, `HOST_STATUS_ADDR, 32'h0);
    `CHK("idle status", 6'h00, d[5:0])
    apb(1'b0, 12'hFF0, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    // Power-up sequence with a random reference level
    ev = rnd();
    lvl = ev[0];
    t0 = cyc;
    apb(1'b1, `HOST_CTRL_ADDR, {30'h0, lvl, 1'b1});
    wait_bit(`STAT_READY_BIT);
    `CHK("init wait", 1'b1, (cyc - t0) >= PWR + 3 + 25 + CAL)
    `CHK("calibration ran", 1'b1, cal_seen)
    `CHK("reference_buffer_config_pin level", lvl, reference_buffer_config_pin_mode)
    conv(1'b0, 8'h8F, 8'h00);
    `CHK("code a default", 8'h00, d[7:0])
    conv(1'b0, 8'h92, 8'h00);
    `CHK("code b default", 8'h00, d[7:0])
    // Every bypass and coding pair; junk in reserved bits gets masked
    for (int i = 0; i < 4; i++) begin
      ev = rnd();
      conv(1'b1, 8'h24, {5'h00, i[1], 2'h0});
      conv(1'b1, 8'h8F, (ev[7:0] & 8'hFD) | {6'h00, i[0], 1'b0});
      conv(1'b1, 8'h92, {6'h00, ~i[0], 1'b0});
      conv(1'b0, 8'h8F, 8'h00);
      `CHK("code a reg", {6'h00, i[0], 1'b0}, d[7:0])
      sample_chk(32'h7FFF8000, i[1], i[0], ~i[0]);
      sample_chk(rnd(), i[1], i[0], ~i[0]);
    end
    // Software reset restores defaults and clears itself
    apb(1'b1, `HOST_CTRL_ADDR, {28'h0, 1'b1, 1'b0, lvl, 1'b0});
    wait_bit(`STAT_READY_BIT);
    conv(1'b0, 8'h8F, 8'h00);
    `CHK("code a after soft", 8'h00, d[7:0])
    conv(1'b0, 8'h24, 8'h00);
    `CHK("bypass after soft", 8'h00, d[7:0])
    conv(1'b0, 8'h00, 8'h00);
    `CHK("soft bit cleared", 8'h00, d[7:0])
    sample_chk(rnd(), 1'b0, 1'b0, 1'b0);
    // Hardware reset during operation
    conv(1'b1, 8'h92, 8'h02);
    // Opposite reference level, so both levels reach the converter
    apb(1'b1, `HOST_CTRL_ADDR, {29'h0, 1'b1, ~lvl, 1'b0});
    wait_bit(`STAT_READY_BIT);
    conv(1'b0, 8'h92, 8'h00);
    `CHK("code b after hard", 8'h00, d[7:0])
    `CHK("reference_buffer_config_pin after hard", ~lvl, reference_buffer_config_pin_mode)
    close_out();
  end
endmodule
